// ---- logic/vram_refresh_pkg.sv ----
// Constants shared by the refresh and wait-state control block
package vram_refresh_pkg;
  // Avalon register byte offsets
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_REFRESH_ADDR = 4'h8;
  // Control register fields
  localparam int CTL_STROBE_CFG_LSB = 0;
  localparam int CTL_REFRESH_TYPE = 2;
  localparam int CTL_SCRUB_EN = 3;
  localparam int CTL_LOW_TIME_LSB = 4;
  localparam int CTL_PRECHARGE_LSB = 6;
  localparam int CTL_OUTPUT_TYPE = 8;
  localparam int CTL_WAIT_DELAY_LSB = 9;
  localparam int CTL_BURST_TOGGLE = 11;
  localparam int CTL_WIDTH = 12;
  localparam logic [11:0] CTL_RESET = 12'h002;
  // Status register fields
  localparam int STS_REFRESH = 0;
  localparam int STS_ACCESS = 1;
  localparam int STS_PENDING = 2;
  // Strobe grouping encodings
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_PAIRS = 2'h1;
  localparam logic [1:0] CFG_ALL = 2'h2;
  // Offsets added to the 2-bit time fields
  localparam logic [3:0] LOW_TIME_BASE = 4'h2;
  localparam logic [2:0] PRECHARGE_BASE = 3'h1;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TIMEBASE_HZ = 2_000_000;
  localparam int TIMEBASE_DIV = CLK_HZ / TIMEBASE_HZ;
  localparam int TIMEBASE_NS = 500;
  localparam int REFRESH_PERIOD_NS = 15_000;
  localparam int REFRESH_TICKS = REFRESH_PERIOD_NS / TIMEBASE_NS;
  localparam int CLEAR_HOLD_NS = 500;
  localparam int CLEAR_HOLD_CYC = (CLEAR_HOLD_NS * (CLK_HZ / 1_000_000)
                                   + 999) / 1000;
  localparam int WAIT_EXTEND_IN_EXTRA = 1;
  // Refresh sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ANNOUNCE = 4'b0010,
    ST_LOW = 4'b0100,
    ST_PRECHARGE = 4'b1000
  } refresh_state_t;
endpackage

// ---- logic/refresh_timebase.sv ----
// Internal timebase divider and refresh request clock
`timescale 1ns/1ps
`default_nettype none
module refresh_timebase #(
  parameter int DIV = 5,
  parameter int TICKS = 30
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clear,
  output logic tick,
  output logic refresh_due
);
  logic [7:0] div_q;
  logic [7:0] period_q;
  wire div_end = (div_q == 8'(DIV - 1));
  wire period_end = (period_q == 8'(TICKS - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      period_q <= 8'h00;
      tick <= 1'b0;
      refresh_due <= 1'b0;
    end else if (clear) begin
      div_q <= 8'h00;
      period_q <= 8'h00;
      tick <= 1'b0;
      refresh_due <= 1'b0;
    end else begin
      div_q <= div_end ? 8'h00 : div_q + 8'h01;
      tick <= div_end;
      if (div_end) begin
        period_q <= period_end ? 8'h00 : period_q + 8'h01;
      end
      refresh_due <= div_end && period_end;
    end
  end
endmodule
`default_nettype wire

// ---- logic/vram_refresh_wait_control.sv ----
// Refresh sequencer, scrub strobes and CPU wait/acknowledge output
//
// Behaviour
// - Staggered refresh asserts strobes singly, in pairs, or all, one edge apart.
// - Each staggered strobe group holds for the low time, then negates alone.
// - Scrubbing is chosen by config when the refresh type is all-strobe.
// - Scrubbing never runs together with staggered refresh.
// - Scrub column strobe group comes from counter bank bits and config.
// - Address counter is 24 bits (11/11/2) or 22 bits (10/10/2).
// - Counter orders bank, column, row; row in the low bits.
// - Only all-strobe refresh may be extended; staggered never.
// - Extend input resampled each edge; refresh lasts until found low.
// - External request with disable negated clears the address counter.
// - Request then disable held gives a clear and back-to-back refreshes.
// - Request held one timebase period clears the request clock and counter.
// - Wait while precharge, refresh, programmed waits, extend-in or bad grant.
// - Output type bit picks active-low wait or data acknowledge.
// - Wait asserts at access start, negates after programmed edges.
// - After wait negates, it may toggle following the column enables.
// - Access end keeps wait negated until the next access.
// - Acknowledge asserts programmed edges after the strobe start event.
// - Acknowledge may toggle following column enables in burst accesses.
// - Access end negates acknowledge until the next access.
// - Refresh in progress asserts one clock before the first row strobe.
// - Address counter increments once all refresh row strobes negate.
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module vram_refresh_wait_control
  import vram_refresh_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int STROBES = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic ext_refresh_request_n,
  input wire logic refresh_disable_n,
  input wire logic extend_refresh,
  input wire logic access_request_n,
  input wire logic chip_select_n,
  input wire logic wait_extend_in_n,
  input wire logic second_port_grant_n,
  input wire logic [STROBES-1:0] byte_column_enable_n,
  output logic [STROBES-1:0] row_strobe_n,
  output logic [STROBES-1:0] column_strobe_n,
  output logic refresh_in_progress_n,
  output logic wait_ack_n,
  output logic [ADDR_W-1:0] refresh_addr
);
  localparam int SW = 7 + STROBES;

  // Pins pass two flip-flops before use
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  wire [SW-1:0] pins_raw = {byte_column_enable_n, second_port_grant_n,
    wait_extend_in_n, chip_select_n, access_request_n, extend_refresh,
    refresh_disable_n, ext_refresh_request_n};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire ext_req = !sync2_q[0];
  wire disable_on = !sync2_q[1];
  wire extend_on = sync2_q[2];
  wire acc_req = !sync2_q[3];
  wire chip_sel = !sync2_q[4];
  wire wait_extend_in_on = !sync2_q[5];
  wire grant_ok = !sync2_q[6];
  wire byte_column_enable_all_off = &sync2_q[SW-1:7];

  // Control register and bus slave
  logic [CTL_WIDTH-1:0] ctl_q;
  logic waitrequest_q;
  wire req = read || write;
  wire wr_take = write && !waitrequest_q;

  wire [1:0] strobe_cfg = ctl_q[CTL_STROBE_CFG_LSB +: 2];
  wire staggered = ctl_q[CTL_REFRESH_TYPE];
  wire scrub_ok = ctl_q[CTL_SCRUB_EN] && !staggered;
  wire [3:0] low_time = {2'b00, ctl_q[CTL_LOW_TIME_LSB +: 2]} + LOW_TIME_BASE;
  wire [2:0] pre_time = {1'b0, ctl_q[CTL_PRECHARGE_LSB +: 2]} + PRECHARGE_BASE;
  wire ack_mode = ctl_q[CTL_OUTPUT_TYPE];
  wire [1:0] wait_delay = ctl_q[CTL_WAIT_DELAY_LSB +: 2];
  wire burst_en = ctl_q[CTL_BURST_TOGGLE];

  // Refresh request clock clearing
  logic [3:0] hold_q;
  logic clk_clear_q;
  logic tick;
  logic refresh_due;
  wire clear_cond = ext_req && !disable_on;
  wire hold_full = (hold_q == 4'(CLEAR_HOLD_CYC - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 4'h0;
      clk_clear_q <= 1'b0;
    end else begin
      hold_q <= (clear_cond && !hold_full) ? hold_q + 4'h1 : 4'h0;
      clk_clear_q <= clear_cond && hold_full;
    end
  end

  refresh_timebase #(
    .DIV(TIMEBASE_DIV),
    .TICKS(REFRESH_TICKS)
  ) u_timebase (
    .clock(clock),
    .rst_n(rst_n),
    .clear(clk_clear_q),
    .tick(tick),
    .refresh_due(refresh_due)
  );

  // Strobe start offset per grouping
  function automatic logic [3:0] strobe_offset(input logic [1:0] cfg,
                                               input int idx);
    case (cfg)
      CFG_SINGLE: strobe_offset = 4'(idx);
      CFG_PAIRS: strobe_offset = 4'(idx / 2);
      default: strobe_offset = 4'h0;
    endcase
  endfunction

  // Refresh sequencer
  refresh_state_t state_q;
  refresh_state_t state_d;
  logic [3:0] step_q;
  logic [3:0] step_d;
  logic [2:0] pre_q;
  logic pending_q;
  logic access_q;
  logic [ADDR_W-1:0] addr_q;

  wire [1:0] eff_cfg = staggered ? strobe_cfg : CFG_ALL;
  wire [3:0] max_off = strobe_offset(eff_cfg, STROBES - 1);
  wire [3:0] last_step = max_off + low_time - 4'h1;
  wire at_end = (step_q == last_step);
  wire extending = !staggered && extend_on;
  wire acc_start = chip_sel && acc_req && !access_q;
  wire start_ok = pending_q && !access_q && !acc_start;
  wire refresh_done = (state_q == ST_LOW) && at_end && !extending;
  wire pending_set = (refresh_due && !disable_on)
                     || (ext_req && disable_on);

  always_comb begin
    state_d = state_q;
    step_d = step_q;
    case (state_q)
      ST_IDLE: begin
        if (start_ok) begin
          state_d = ST_ANNOUNCE;
        end
      end
      ST_ANNOUNCE: begin
        state_d = ST_LOW;
        step_d = 4'h0;
      end
      ST_LOW: begin
        if (refresh_done) begin
          state_d = ST_PRECHARGE;
        end else if (!at_end) begin
          step_d = step_q + 4'h1;
        end
      end
      ST_PRECHARGE: begin
        if (pre_q == 3'h1) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      step_q <= 4'h0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 3'h0;
    end else if (refresh_done) begin
      pre_q <= pre_time;
    end else if (pre_q != 3'h0) begin
      pre_q <= pre_q - 3'h1;
    end
  end

  // Set wins over the clear at the end of a refresh
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= pending_set || (pending_q && !refresh_done);
    end
  end

  // Refresh address counter: bank, column, row from msb down
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
    end else if (clear_cond) begin
      addr_q <= '0;
    end else if (refresh_done) begin
      addr_q <= addr_q + ADDR_W'(1);
    end
  end

  // Row and column strobe decode from the next sequencer state
  wire low_next = (state_d == ST_LOW);
  wire [1:0] bank = addr_q[ADDR_W-1 -: 2];
  logic [STROBES-1:0] row_on_d;
  logic [STROBES-1:0] col_on_d;
  logic [STROBES-1:0] scrub_mask;

  always_comb begin
    case (strobe_cfg)
      CFG_SINGLE: scrub_mask = STROBES'(1) << bank;
      CFG_PAIRS: scrub_mask = bank[0] ? STROBES'(4'hc) : STROBES'(4'h3);
      default: scrub_mask = '1;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < STROBES; gi++) begin : g_strobe
      wire [3:0] off = strobe_offset(eff_cfg, gi);
      // Extension holds the step, so all strobes stay low together
      assign row_on_d[gi] = low_next && (step_d >= off)
                            && (step_d < off + low_time);
      assign col_on_d[gi] = low_next && scrub_ok
                            && scrub_mask[gi];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      row_strobe_n <= '1;
      column_strobe_n <= '1;
      refresh_in_progress_n <= 1'b1;
      refresh_addr <= '0;
    end else begin
      row_strobe_n <= ~row_on_d;
      column_strobe_n <= ~col_on_d;
      refresh_in_progress_n <= !(state_d == ST_ANNOUNCE
                                 || state_d == ST_LOW);
      refresh_addr <= addr_q;
    end
  end

  // Access tracking and wait counting
  logic [2:0] wcnt_q;
  logic done_q;
  wire blocked = (state_q != ST_IDLE) || (pre_q != 3'h0)
                 || !grant_ok;
  wire [2:0] target = {1'b0, wait_delay}
                      + (wait_extend_in_on ? 3'(WAIT_EXTEND_IN_EXTRA) : 3'h0);
  wire in_access = (access_q || acc_start) && acc_req;
  // Acknowledge counts from the strobe start, so blocking stalls it
  // Start cycle is never ready, so wait shows even with a zero delay
  wire count_en = access_q && acc_req
                  && (!ack_mode || !blocked);
  wire ready = access_q && acc_req && !blocked
               && (wcnt_q >= target);
  wire burst_gap = burst_en && done_q && byte_column_enable_all_off;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      access_q <= 1'b0;
      wcnt_q <= 3'h0;
      done_q <= 1'b0;
    end else if (!in_access) begin
      access_q <= 1'b0;
      wcnt_q <= 3'h0;
      done_q <= 1'b0;
    end else begin
      access_q <= 1'b1;
      if (count_en && wcnt_q != 3'h7) begin
        wcnt_q <= wcnt_q + 3'h1;
      end
      done_q <= done_q || ready;
    end
  end

  // Toggling in bursts follows the column enables once released
  wire wait_on = in_access && (!(ready || done_q) || burst_gap);
  wire ack_on = in_access && (ready || done_q) && !burst_gap;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_ack_n <= 1'b1;
    end else begin
      // Negated whenever no access is active
      wait_ack_n <= ack_mode ? !ack_on : !wait_on;
    end
  end

  // Bus slave: one wait cycle, then the answer
  wire [31:0] status_word = {29'h0, pending_q, access_q,
                             state_q != ST_IDLE};
  wire [31:0] read_mux = (address == OFF_CONTROL) ? 32'(ctl_q)
                       : (address == OFF_STATUS) ? status_word
                       : (address == OFF_REFRESH_ADDR) ? 32'(addr_q)
                       : 32'h0000_0000;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_q <= 1'b1;
      readdata <= 32'h0000_0000;
      ctl_q <= CTL_RESET;
    end else begin
      waitrequest_q <= !(req && waitrequest_q);
      if (read && waitrequest_q) begin
        readdata <= read_mux;
      end
      if (wr_take && address == OFF_CONTROL) begin
        ctl_q <= writedata[CTL_WIDTH-1:0];
      end
    end
  end

  assign waitrequest = waitrequest_q;
endmodule
`default_nettype wire

// ---- sim/vram_refresh_wait_control_properties.sv ----
// Port-level checks for the refresh and wait control block
`timescale 1ns/1ps
`default_nettype none
module vram_refresh_wait_control_properties #(
  parameter int ADDR_W = 24,
  parameter int STROBES = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic refresh_disable_n,
  input wire logic access_request_n,
  input wire logic [STROBES-1:0] row_strobe_n,
  input wire logic [STROBES-1:0] column_strobe_n,
  input wire logic refresh_in_progress_n,
  input wire logic wait_ack_n,
  input wire logic [ADDR_W-1:0] refresh_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire rows_idle = &row_strobe_n;
  a_refresh_in_progress_leads_rows: assert property (
    $fell(refresh_in_progress_n) |=> !row_strobe_n[0])
    else $error("row strobe late");
  a_rows_need_refresh_in_progress: assert property (
    !rows_idle |-> !refresh_in_progress_n) else $error("rows without refresh_in_progress");
  a_scrub_in_refresh: assert property (
    !(&column_strobe_n) |-> !rows_idle) else $error("column outside refresh");
  a_low_minimum: assert property (
    $fell(row_strobe_n[0]) |=> !row_strobe_n[0]) else $error("row low short");
  a_addr_step: assert property (
    $rose(rows_idle) && !refresh_disable_n
    |=> refresh_addr == $past(refresh_addr) + 1'b1) else $error("no step");
  a_bus_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest) else $error("bus late");
  a_bus_single: assert property (
    !waitrequest |=> waitrequest) else $error("waitrequest stuck low");
  a_wait_released: assert property (
    access_request_n [*4] |-> wait_ack_n) else $error("wait after access");
  c_refresh: cover property ($fell(refresh_in_progress_n));
  c_scrub: cover property (!(&column_strobe_n));
  c_wait: cover property ($fell(wait_ack_n));
endmodule
`default_nettype wire

// ---- sim/refresh_partner.sv ----
// Behavioural model of the outside refresh control logic
`timescale 1ns/1ps
`default_nettype none
module refresh_partner (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] row_strobe_n,
  input wire logic req_on,
  input wire logic [3:0] ext_len,
  output logic ext_refresh_request_n,
  output logic extend_refresh
);
  logic [3:0] cnt_q;
  logic row0_q;
  // No write port here: write enable stays high in scrub reads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      row0_q <= 1'b1;
      ext_refresh_request_n <= 1'b1;
    end else begin
      row0_q <= row_strobe_n[0];
      ext_refresh_request_n <= !req_on;
      if (row0_q && !row_strobe_n[0])
        cnt_q <= ext_len;
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
    end
  end
  // Raised only after the start edge, so slow answers are exercised
  assign extend_refresh = (cnt_q != 4'h0);
endmodule
`default_nettype wire

// ---- sim/vram_refresh_wait_control_tb.sv ----
// Self-checking bench for the refresh and wait control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module vram_refresh_wait_control_tb
  import vram_refresh_pkg::*;
;
  logic clock = 0, rst_n = 0, read = 0, write = 0, req_on = 0;
  logic refresh_disable_n = 0, access_request_n = 1, chip_select_n = 1;
  logic wait_extend_in_n = 1, second_port_grant_n = 0;
  logic extend_refresh, ext_refresh_request_n, waitrequest;
  logic refresh_in_progress_n, wait_ack_n;
  logic [3:0] address = 0, ext_len = 0, byte_column_enable_n = 0;
  logic [3:0] row_strobe_n, column_strobe_n;
  logic [31:0] writedata = 0, readdata, q;
  logic [23:0] refresh_addr;
  int error_cnt = 0, n_compared = 0;
  always #50 clock = ~clock;
  vram_refresh_wait_control vram_refresh_wait_control_inst (.*);
  refresh_partner refresh_partner_inst (.*);
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(negedge clock); while (waitrequest !== 1'b0);
    @(posedge clock);
    q = readdata;
    read <= 0;
    write <= 0;
  endtask
  task automatic refresh(input logic [11:0] ctl, input logic [3:0] el,
                         output int f[4], output int l[4], output logic c);
    bus(1, OFF_CONTROL, {20'h0_0000, ctl});
    ext_len <= el;
    req_on <= 1;
    @(posedge clock);
    req_on <= 0;
    f = '{0, 0, 0, 0};
    l = '{0, 0, 0, 0};
    c = 0;
    for (int k = 0; k < 40; k++) begin
      @(negedge clock);
      for (int i = 0; i < 4; i++) if (row_strobe_n[i] === 1'b0) begin
        if (l[i] == 0) f[i] = k;
        l[i]++;
      end
      if (column_strobe_n !== 4'hf) c = 1;
    end
  endtask
  // CPU side: holds its cycle for 20 clocks, whatever the wait output says
  task automatic access(input logic [11:0] ctl, input logic wi,
                        input int gb, output int f, output int lo);
    bus(1, OFF_CONTROL, {20'h0_0000, ctl});
    wait_extend_in_n <= !wi;
    second_port_grant_n <= (gb > 0);
    chip_select_n <= 0;
    access_request_n <= 0;
    f = -1;
    lo = 0;
    for (int k = 0; k < 20; k++) begin
      @(posedge clock);
      if (k == gb) second_port_grant_n <= 0;
      if (k == 12) byte_column_enable_n <= 4'hf;
      @(negedge clock);
      if (wait_ack_n === 1'b0 && k < 12) begin
        if (f < 0) f = k;
        lo++;
      end
    end
    q[0] = wait_ack_n;
    @(posedge clock);
    chip_select_n <= 1;
    access_request_n <= 1;
    byte_column_enable_n <= 0;
    wait_extend_in_n <= 1;
    repeat (4) @(posedge clock);
    `CHK(wait_ack_n, 1'b1)
  endtask
  task automatic t_regs();
    bus(0, OFF_CONTROL, 0);
    `CHK(q[11:0], CTL_RESET)
    bus(1, OFF_CONTROL, 32'h0000_0a5d);
    bus(0, OFF_CONTROL, 0);
    `CHK(q[11:0], 12'ha5d)
    bus(0, 4'hc, 0);
    `CHK(q, 32'h0000_0000)
    $display("test done: registers");
  endtask
  task automatic t_strobes();
    int f[4], l[4];
    logic c;
    logic [23:0] a0;
    a0 = refresh_addr;
    refresh(12'h03a, 0, f, l, c);
    `CHK(l[0], 5)
    `CHK(f[3], f[0])
    `CHK(c, 1'b1)
    `CHK(refresh_addr, a0 + 24'h1)
    refresh(12'h03a, 4, f, l, c);
    `CHK(l[0] > 5, 1'b1)
    refresh(12'h03d, 4, f, l, c);
    `CHK(f[1], f[0])
    `CHK(f[2], f[0] + 1)
    `CHK(l[0], 5)
    `CHK(l[2], 5)
    `CHK(c, 1'b0)
    refresh(12'h03c, 0, f, l, c);
    `CHK(f[3], f[0] + 3)
    $display("test done: refresh strobes");
  endtask
  task automatic t_ext_control();
    int n;
    logic p;
    bus(1, OFF_CONTROL, 32'h0000_0002);
    refresh_disable_n <= 1;
    repeat (3) @(posedge clock);
    req_on <= 1;
    // Request must lead the disable by a clock at the partner's output
    repeat (2) @(posedge clock);
    refresh_disable_n <= 0;
    n = 0;
    p = 1;
    for (int k = 0; k < 80; k++) begin
      @(posedge clock);
      if (k == 40) req_on <= 0;
      @(negedge clock);
      if (!p && row_strobe_n[0]) n++;
      p = row_strobe_n[0];
    end
    `CHK(n > 1, 1'b1)
    `CHK(refresh_addr, 24'(n))
    refresh_disable_n <= 1;
    req_on <= 1;
    repeat (8) @(posedge clock);
    req_on <= 0;
    repeat (3) @(posedge clock);
    `CHK(refresh_addr, 24'h00_0000)
    p = 0;
    repeat (120) @(posedge clock) if (refresh_in_progress_n === 1'b0) p = 1;
    `CHK(p, 1'b0)
    refresh_disable_n <= 0;
    $display("test done: external refresh control");
  endtask
  task automatic t_wait_ack();
    int f, lo, fw;
    access(12'h200, 0, 0, fw, lo);
    `CHK(lo, 2)
    access(12'h200, 1, 0, f, lo);
    `CHK(lo, 3)
    access(12'h000, 0, 9, f, lo);
    `CHK(lo > 3, 1'b1)
    access(12'h800, 0, 0, f, lo);
    `CHK(q[0], 1'b0)
    access(12'h300, 0, 0, f, lo);
    `CHK(f > fw, 1'b1)
    `CHK(lo, 12 - f)
    access(12'hb00, 0, 0, f, lo);
    `CHK(q[0], 1'b1)
    $display("test done: wait and acknowledge");
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1;
    t_regs();
    t_strobes();
    t_ext_control();
    t_wait_ack();
    finish_test();
  end
  // About 600 cycles expected; a hang ends here
  initial begin
    repeat (6000) @(posedge clock);
    error_cnt++;
    finish_test();
  end
endmodule
bind vram_refresh_wait_control vram_refresh_wait_control_properties #(
  .ADDR_W(ADDR_W), .STROBES(STROBES)) props_inst (.*);
`default_nettype wire
